//--- dv/ted_checker_sva.sv
// Port checker for the transient event detector
`timescale 1ns/10ps
module ted_checker_sva (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic [7:0] regAddr,
    input wire logic regWrEn,
    input wire logic [7:0] regWrData,
    input wire logic regRdEn,
    input wire logic [7:0] regRdData,
    input wire logic transientIntEnable,
    input wire logic motionCondition,
    input wire logic transientEventActive,
    input wire logic transientIrq,
    input wire logic motionEventFlag,
    input wire logic debounceStep
);
    logic [7:0] motionCnt_q;
    logic srcRd;
    assign srcRd = regRdEn && (regAddr == ted_pkg::ADDR_TRANS_SRC);
    // Shadow of the motion count so reads and zero-count hits can be judged
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
            motionCnt_q <= 8'h00;
        else if (regWrEn && regAddr == ted_pkg::ADDR_MOTION_COUNT)
            motionCnt_q <= regWrData;
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    // Gap holds for any base tick of at least 4 cycles, the bench's shortened tick included
    sequence s_quiet_gap;
        !debounceStep [*3];
    endsequence
    a_irq_gate: assert property (transientIrq == (transientEventActive && transientIntEnable))
        else $error("transient irq not gated by its enable");
    a_step_gap: assert property (debounceStep |=> s_quiet_gap)
        else $error("debounce steps too close");
    a_active_cause: assert property ($changed(transientEventActive) |-> $past(debounceStep || srcRd))
        else $error("event active moved without step or read");
    a_read_clear: assert property (srcRd && !debounceStep |=> !transientEventActive)
        else $error("source read did not clear event active");
    a_src_active_bit: assert property (srcRd |=> regRdData[6] == $past(transientEventActive))
        else $error("source bit 6 differs from event active");
    a_count_readback: assert property (regRdEn && regAddr == ted_pkg::ADDR_MOTION_COUNT
        |=> regRdData == $past(motionCnt_q))
        else $error("motion count read back wrong");
    a_flag_at_step: assert property ($changed(motionEventFlag) |-> $past(debounceStep))
        else $error("motion flag moved off a step");
    a_flag_needs_cond: assert property (debounceStep && !motionCondition |=> !motionEventFlag)
        else $error("motion flag without condition");
    a_zero_count_hit: assert property (debounceStep && motionCondition && motionCnt_q == 8'h00
        |=> motionEventFlag)
        else $error("zero count did not hit at once");
endmodule // ted_checker_sva

bind transient_event_detector ted_checker_sva ted_checker_sva_inst (
    .sys_clk(sys_clk), .reset_n(reset_n), .regAddr(regAddr), .regWrEn(regWrEn),
    .regWrData(regWrData), .regRdEn(regRdEn), .regRdData(regRdData),
    .transientIntEnable(transientIntEnable), .motionCondition(motionCondition),
    .transientEventActive(transientEventActive), .transientIrq(transientIrq),
    .motionEventFlag(motionEventFlag), .debounceStep(debounceStep));

//--- dv/ted_host_model.sv
// Host model that reaches the detector registers
`timescale 1ns/10ps
module ted_host_model (
    input wire logic sys_clk,
    input wire logic [7:0] regRdData,
    output logic [7:0] regAddr,
    output logic regWrEn,
    output logic [7:0] regWrData,
    output logic regRdEn
);
    initial
    begin
        regAddr = 8'h00;
        regWrEn = 1'b0;
        regWrData = 8'h00;
        regRdEn = 1'b0;
    end
    // Idle address and data are inverted so stale values never look valid
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge sys_clk);
        regAddr = a;
        regWrData = d;
        regWrEn = 1'b1;
        @(negedge sys_clk);
        regWrEn = 1'b0;
        regAddr = ~a;
        regWrData = ~d;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge sys_clk);
        regAddr = a;
        regRdEn = 1'b1;
        @(negedge sys_clk);
        regRdEn = 1'b0;
        regAddr = ~a;
        d = regRdData;
    endtask
endmodule // ted_host_model

//--- dv/test_transient_event_detector.sv
// Self-checking bench for the transient event detector
`timescale 1ns/10ps
module test_transient_event_detector;
    logic sys_clk = 1'b0;
    logic reset_n = 1'b0;
    logic [7:0] regAddr;
    logic regWrEn;
    logic [7:0] regWrData;
    logic regRdEn;
    logic [7:0] regRdData;
    logic [2:0] outputDataRate = 3'h0;
    ted_pkg::ted_mode_type oversampleMode = ted_pkg::MODE_NORMAL;
    logic lowNoise = 1'b0;
    logic [2:0][13:0] hpfAccel = '0;
    logic [2:0][13:0] rawAccel = '0;
    logic transientIntEnable = 1'b0;
    logic motionCondition = 1'b0;
    logic motionDebounceMode = 1'b0;
    logic transientEventActive;
    logic transientIrq;
    logic motionEventFlag;
    logic debounceStep;
    int errorCnt = 0;
    int samplesChecked = 0;

    // Short base tick keeps the longest step at 512 cycles
    transient_event_detector #(.ACCEL_W(14), .BASE_CYCLES(4)) transient_event_detector_inst (
        .sys_clk(sys_clk), .reset_n(reset_n), .regAddr(regAddr), .regWrEn(regWrEn),
        .regWrData(regWrData), .regRdEn(regRdEn), .regRdData(regRdData),
        .outputDataRate(outputDataRate), .oversampleMode(oversampleMode),
        .lowNoise(lowNoise), .hpfAccel(hpfAccel), .rawAccel(rawAccel),
        .transientIntEnable(transientIntEnable), .motionCondition(motionCondition),
        .motionDebounceMode(motionDebounceMode), .transientEventActive(transientEventActive),
        .transientIrq(transientIrq), .motionEventFlag(motionEventFlag),
        .debounceStep(debounceStep));
    ted_host_model ted_host_model_inst (.sys_clk(sys_clk), .regRdData(regRdData),
        .regAddr(regAddr), .regWrEn(regWrEn), .regWrData(regWrData), .regRdEn(regRdEn));

    initial
    begin
        forever #12.5 sys_clk = ~sys_clk;
    end

    task automatic final_report();
        $display("Checks %0d mismatches %0d", samplesChecked, errorCnt);
        if (errorCnt == 0 && samplesChecked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        samplesChecked++;
        if (seen !== exp)
        begin
            errorCnt++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // Current cycle counts, since its closing edge still samples the inputs
    task automatic wait_step(output int n);
        n = 0;
        while (debounceStep !== 1'b1 && n < 3000)
        begin
            @(negedge sys_clk);
            n++;
        end
        if (n >= 3000)
        begin
            chk("step wait", 16'h0000, 16'h0001);
            final_report();
        end
    endtask
    task automatic steps(input int k);
        int n;
        repeat (k)
        begin
            wait_step(n);
            @(negedge sys_clk);
        end
    endtask
    task automatic rc(input logic [7:0] a, input logic [7:0] e, input string nm);
        logic [7:0] d;
        ted_host_model_inst.rd(a, d);
        chk(nm, 16'(d), 16'(e));
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        ted_host_model_inst.wr(a, d);
    endtask

    task automatic test_regs();
        rc(8'h18, 8'h00, "motion count");
        rc(8'h20, 8'h00, "trans count");
        rc(8'h1f, 8'h00, "threshold");
        rc(8'h1d, 8'h00, "config");
        rc(8'h1e, 8'h00, "source");
        rc(8'h33, 8'h00, "unmapped");
        wr(8'h1d, 8'hff);
        rc(8'h1d, 8'h1f, "config bits");
        wr(8'h1e, 8'hff);
        rc(8'h1e, 8'h00, "source write");
        wr(8'h18, 8'ha5);
        rc(8'h18, 8'ha5, "motion count rw");
        wr(8'h20, 8'h5a);
        rc(8'h20, 8'h5a, "trans count rw");
        wr(8'h1f, 8'h85);
        rc(8'h1f, 8'h85, "threshold rw");
        wr(8'h1d, 8'h00);
        wr(8'h18, 8'h00);
        wr(8'h20, 8'h00);
    endtask
    task automatic test_transient();
        wr(8'h1f, 8'h05);
        wr(8'h1d, 8'h02);
        transientIntEnable = 1'b1;
        hpfAccel[0] = 14'h000a;
        hpfAccel[1] = 14'h3ff6;
        steps(1);
        chk("active", 16'(transientEventActive), 16'h0001);
        chk("irq", 16'(transientIrq), 16'h0001);
        rc(8'h1e, 8'h42, "source x pos");
        hpfAccel[0] = 14'h3ff6;
        steps(1);
        rc(8'h1e, 8'h43, "source x neg");
        hpfAccel[0] = 14'h0005;
        steps(1);
        chk("equal ths", 16'(transientEventActive), 16'h0000);
        wr(8'h1d, 8'h06);
        transientIntEnable = 1'b0;
        steps(1);
        chk("irq off", 16'(transientIrq), 16'h0000);
        rc(8'h1e, 8'h4c, "source y neg");
        hpfAccel = '0;
        wr(8'h1d, 8'h03);
        rawAccel[0] = 14'h000a;
        steps(1);
        rc(8'h1e, 8'h42, "bypass raw");
        wr(8'h1d, 8'h02);
        steps(1);
        rc(8'h1e, 8'h00, "filtered live");
        rawAccel = '0;
    endtask
    task automatic test_latch();
        wr(8'h1d, 8'h1a);
        hpfAccel[0] = 14'h000a;
        steps(1);
        hpfAccel[0] = 14'h3ff6;
        hpfAccel[2] = 14'h3ff6;
        steps(1);
        hpfAccel = '0;
        steps(1);
        rc(8'h1e, 8'h72, "latched source");
        chk("active cleared", 16'(transientEventActive), 16'h0000);
        steps(1);
        rc(8'h1e, 8'h00, "after clear");
        wr(8'h1d, 8'h02);
        wr(8'h1f, 8'h7f);
        hpfAccel[0] = 14'h0040;
        steps(1);
        chk("full ths", 16'(transientEventActive), 16'h0000);
        lowNoise = 1'b1;
        steps(1);
        chk("low noise ths", 16'(transientEventActive), 16'h0001);
        lowNoise = 1'b0;
        wr(8'h1f, 8'h85);
        wr(8'h20, 8'h02);
        hpfAccel[0] = 14'h0000;
        steps(1);
        hpfAccel[0] = 14'h000a;
        steps(1);
        chk("trans count 1", 16'(transientEventActive), 16'h0000);
        steps(1);
        chk("trans count 2", 16'(transientEventActive), 16'h0001);
        hpfAccel = '0;
        wr(8'h20, 8'h00);
    endtask
    task automatic test_motion();
        wr(8'h18, 8'h02);
        motionCondition = 1'b1;
        steps(1);
        chk("flag step 1", 16'(motionEventFlag), 16'h0000);
        steps(1);
        chk("flag step 2", 16'(motionEventFlag), 16'h0001);
        steps(1);
        chk("flag saturate", 16'(motionEventFlag), 16'h0001);
        motionCondition = 1'b0;
        steps(1);
        motionCondition = 1'b1;
        steps(1);
        chk("flag decrement", 16'(motionEventFlag), 16'h0001);
        motionDebounceMode = 1'b1;
        motionCondition = 1'b0;
        steps(1);
        motionCondition = 1'b1;
        steps(1);
        chk("flag clear", 16'(motionEventFlag), 16'h0000);
        wr(8'h18, 8'h00);
        steps(1);
        chk("flag zero count", 16'(motionEventFlag), 16'h0001);
        motionCondition = 1'b0;
    endtask
    task automatic test_step_rate();
        logic [2:0] output_data_rate [5] = '{3'h1, 3'h3, 3'h6, 3'h7, 3'h7};
        ted_pkg::ted_mode_type md [5] = '{ted_pkg::MODE_NORMAL, ted_pkg::MODE_HIGH_RESOLUTION_MODE,
            ted_pkg::MODE_LOW_POWER_LOW_NOISE_MODE, ted_pkg::MODE_LP, ted_pkg::MODE_NORMAL};
        int units [5] = '{2, 2, 64, 128, 16};
        int n;
        for (int i = 0; i < 5; i++)
        begin
            outputDataRate = output_data_rate[i];
            oversampleMode = md[i];
            steps(2);
            wait_step(n);
            chk("step cycles", 16'(n + 1), 16'(4 * units[i]));
        end
    endtask

    initial
    begin
        repeat (12) @(negedge sys_clk);
        reset_n = 1'b1;
        test_regs();
        test_transient();
        test_latch();
        test_motion();
        test_step_rate();
        final_report();
    end
endmodule // test_transient_event_detector

//--- pkg/ted_dbc_if.sv
// Carrier between the detector and one debounce counter
`timescale 1ns/10ps
interface ted_dbc_if;
    logic step;
    logic cond;
    logic clearMode;
    logic [ted_pkg::CNT_W-1:0] limit;
    logic hit;
    logic match;

    modport ctrl (output step, output cond, output clearMode, output limit,
                  input hit, input match);
    modport cnt (input step, input cond, input clearMode, input limit,
                 output hit, output match);
endinterface

//--- pkg/ted_pkg.sv
// Constants, types and step-rate helper for the transient event detector
package ted_pkg;

    // Register offsets
    localparam logic [7:0] ADDR_MOTION_COUNT = 8'h18;
    localparam logic [7:0] ADDR_TRANS_CFG = 8'h1d;
    localparam logic [7:0] ADDR_TRANS_SRC = 8'h1e;
    localparam logic [7:0] ADDR_TRANS_THS = 8'h1f;
    localparam logic [7:0] ADDR_TRANS_COUNT = 8'h20;

    // Reset values
    localparam logic [7:0] RST_MOTION_COUNT = 8'h00;
    localparam logic [7:0] RST_TRANS_CFG = 8'h00;
    localparam logic [7:0] RST_TRANS_THS = 8'h00;
    localparam logic [7:0] RST_TRANS_COUNT = 8'h00;
    localparam logic [7:0] READ_ZERO = 8'h00;

    // Config fields; bits 7:5 are reserved and read as zero
    localparam logic [7:0] CFG_WRITE_MASK = 8'h1f;
    localparam int CFG_BYPASS_BIT = 0;
    localparam int CFG_AXIS_EN_LSB = 1;
    localparam int CFG_LATCH_BIT = 4;

    // Source fields: axis i has polarity at 2*i and event at 2*i+1
    localparam int SRC_AXIS_STRIDE = 2;
    localparam int SRC_POL_OFS = 0;
    localparam int SRC_EVT_OFS = 1;
    localparam int SRC_ACTIVE_BIT = 6;

    // Threshold fields
    localparam int THS_MODE_BIT = 7;
    localparam int THS_W = 7;
    localparam logic [6:0] LOW_NOISE_THS_MAX = 7'h3f;

    localparam int AXES = 3;
    localparam int CNT_W = 8;
    localparam int UNIT_W = 10;

    // Time base: every step is a whole number of 1.25 ms units
    localparam int CLK_MHZ = 40;
    localparam int STEP_BASE_US = 1250;
    localparam int STEP_BASE_CYCLES = STEP_BASE_US * CLK_MHZ;
    localparam int CAP_NORMAL_US = 20000;
    localparam int CAP_LOW_POWER_LOW_NOISE_MODE_US = 80000;
    localparam int CAP_HIGH_RESOLUTION_MODE_US = 2500;
    localparam int CAP_LP_US = 160000;
    localparam int ODR_PERIOD_US [8] = '{1250, 2500, 5000, 10000, 20000, 80000, 160000, 640000};

    typedef enum logic [1:0] {MODE_NORMAL, MODE_LOW_POWER_LOW_NOISE_MODE, MODE_HIGH_RESOLUTION_MODE, MODE_LP} ted_mode_type;

    // Step length in 1.25 ms units: the sample period, capped per mode
    function automatic logic [UNIT_W-1:0] ted_step_units(input logic [2:0] output_data_rate,
                                                        input ted_mode_type mode);
        logic [UNIT_W-1:0] odrUnits;
        logic [UNIT_W-1:0] cap;
        odrUnits = UNIT_W'(ODR_PERIOD_US[output_data_rate] / STEP_BASE_US);
        unique case (mode)
            MODE_NORMAL: cap = UNIT_W'(CAP_NORMAL_US / STEP_BASE_US);
            MODE_LOW_POWER_LOW_NOISE_MODE: cap = UNIT_W'(CAP_LOW_POWER_LOW_NOISE_MODE_US / STEP_BASE_US);
            MODE_HIGH_RESOLUTION_MODE: cap = UNIT_W'(CAP_HIGH_RESOLUTION_MODE_US / STEP_BASE_US);
            MODE_LP: cap = UNIT_W'(CAP_LP_US / STEP_BASE_US);
        endcase
        return (odrUnits < cap) ? odrUnits : cap;
    endfunction

endpackage

//--- src/ted_debounce.sv
// Saturating debounce counter with decrement or clear on lapse
`timescale 1ns/10ps
module ted_debounce (
    input wire logic sys_clk,
    input wire logic reset_n,
    ted_dbc_if.cnt dbc
);
    typedef struct packed {
        logic [ted_pkg::CNT_W-1:0] count;
        logic match;
    } ted_dbc_state_type;

    ted_dbc_state_type q;
    ted_dbc_state_type d;
    logic [ted_pkg::CNT_W-1:0] satNext;
    logic hitNow;

    always_comb
    begin
        d = q;
        // Lowering the limit below the count pulls the count back to it
        if (q.count >= dbc.limit)
        begin
            satNext = dbc.limit;
        end
        else
        begin
            satNext = q.count + 1'b1;
        end
        // Zero limit fires on the first matching sample
        hitNow = dbc.step && dbc.cond && (satNext == dbc.limit);
        if (dbc.step)
        begin
            d.match = hitNow;
            if (dbc.cond)
            begin
                d.count = satNext;
            end
            else if (dbc.clearMode)
            begin
                d.count = '0;
            end
            else if (q.count != '0)
            begin
                d.count = q.count - 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            q <= '0;
        end
        else
        begin
            q <= d;
        end
    end

    assign dbc.hit = hitNow;
    assign dbc.match = q.match;
endmodule // ted_debounce

//--- src/transient_event_detector.sv
// Transient detector with freefall/motion debounce count and step timer
//
// Operation
// - 8-bit motion debounce count register, resets to zero, sets needed matching samples.
// - Motion flag sets when its debounce counter equals the programmed count.
// - Each debounce counter saturates at its programmed count while condition holds.
// - Motion counter steps once per OUTPUT_DATA_RATE period, capped per oversampling mode.
// - Transient compares filtered acceleration to threshold, otherwise like motion detection.
// - Bypass bit 0 selects filtered data when 0, raw data when 1.
// - Axis event flag only when that axis is enabled and magnitude exceeds threshold.
// - Latch-enable holds flags until source read; otherwise flags follow live status.
// - A source register read clears the interrupt and all source bits, except events set by a step in the same cycle.
// - While latched and active, new axis events may set and update polarity; none clear.
// - Once active under latching, set status bits freeze; unflagged axes may still set.
// - Source holds active at bit 6, Z/Y/X event-polarity pairs below.
// - Active bit is set when any enabled axis event flag is set.
// - Threshold is 7-bit unsigned, 0.063g per step, up to 8g.
// - Low-noise setting limits the effective threshold to 4g.
// - Event flag on exceeding threshold; interrupt only when that interrupt is enabled.
// - Threshold bit 7 picks decrement or clear debounce mode.
// - 8-bit transient debounce count register, resets to zero.
// - Transient counter steps at the OUTPUT_DATA_RATE and oversampling derived rate.
// - Decrement mode lowers counter by one per step; clear mode zeroes it.
// - Motion counter takes its mode bit from the motionDebounceMode input, not from a register in this module.
`timescale 1ns/10ps
module transient_event_detector #(
    parameter int ACCEL_W = 14,
    parameter int BASE_CYCLES = ted_pkg::STEP_BASE_CYCLES
) (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic [7:0] regAddr,
    input wire logic regWrEn,
    input wire logic [7:0] regWrData,
    input wire logic regRdEn,
    output logic [7:0] regRdData,
    input wire logic [2:0] outputDataRate,
    input wire ted_pkg::ted_mode_type oversampleMode,
    input wire logic lowNoise,
    input wire logic [ted_pkg::AXES-1:0][ACCEL_W-1:0] hpfAccel,
    input wire logic [ted_pkg::AXES-1:0][ACCEL_W-1:0] rawAccel,
    input wire logic transientIntEnable,
    input wire logic motionCondition,
    input wire logic motionDebounceMode,
    output logic transientEventActive,
    output logic transientIrq,
    output logic motionEventFlag,
    output logic debounceStep
);
    localparam int PRE_W = $clog2(BASE_CYCLES + 1);
    localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(BASE_CYCLES - 1);

    typedef struct packed {
        logic [7:0] motionCount;
        logic [7:0] cfg;
        logic [7:0] ths;
        logic [7:0] transCount;
        logic [ted_pkg::AXES-1:0] evt;
        logic [ted_pkg::AXES-1:0] pol;
        logic active;
        logic [7:0] rdData;
        logic [PRE_W-1:0] preCnt;
        logic [ted_pkg::UNIT_W-1:0] unitCnt;
        logic step;
    } ted_state_type;

    ted_state_type q;
    ted_state_type d;

    ted_dbc_if transDbc ();
    ted_dbc_if motionDbc ();

    logic [ted_pkg::UNIT_W-1:0] stepUnits;
    logic [ted_pkg::THS_W-1:0] thsEff;
    logic [ted_pkg::AXES-1:0] axisEnable;
    logic [ted_pkg::AXES-1:0] axisOver;
    logic [ted_pkg::AXES-1:0] axisNeg;
    logic [ted_pkg::AXES-1:0] liveEvt;
    logic [ted_pkg::AXES-1:0] livePol;
    logic [7:0] srcView;
    logic readClear;

    // Step length follows rate and mode changes at the next unit boundary
    assign stepUnits = ted_pkg::ted_step_units(outputDataRate, oversampleMode);

    assign axisEnable = q.cfg[ted_pkg::CFG_AXIS_EN_LSB +: ted_pkg::AXES];

    // Full 7-bit range spans 8g whatever the full-scale setting
    always_comb
    begin
        thsEff = q.ths[ted_pkg::THS_W-1:0];
        if (lowNoise && (thsEff > ted_pkg::LOW_NOISE_THS_MAX))
        begin
            thsEff = ted_pkg::LOW_NOISE_THS_MAX;
        end
    end

    // Samples are in threshold units; the most negative value still fits unsigned
    genvar gi;
    generate
        for (gi = 0; gi < ted_pkg::AXES; gi++)
        begin : gen_axis
            logic [ACCEL_W-1:0] sample;
            logic [ACCEL_W-1:0] magnitude;
            assign sample = q.cfg[ted_pkg::CFG_BYPASS_BIT] ? rawAccel[gi] : hpfAccel[gi];
            assign axisNeg[gi] = sample[ACCEL_W-1];
            assign magnitude = axisNeg[gi] ? ACCEL_W'(-sample) : sample;
            // Strictly greater than the threshold counts as an event
            assign axisOver[gi] = axisEnable[gi]
                && (magnitude > ACCEL_W'(thsEff));
        end
    endgenerate

    // Only axes over threshold once the debounce is met report an event
    assign liveEvt = transDbc.hit ? axisOver : '0;
    assign livePol = liveEvt & axisNeg;

    always_comb
    begin
        srcView = ted_pkg::READ_ZERO;
        for (int i = 0; i < ted_pkg::AXES; i++)
        begin
            srcView[i * ted_pkg::SRC_AXIS_STRIDE + ted_pkg::SRC_EVT_OFS] = q.evt[i];
            srcView[i * ted_pkg::SRC_AXIS_STRIDE + ted_pkg::SRC_POL_OFS] = q.pol[i];
        end
        srcView[ted_pkg::SRC_ACTIVE_BIT] = q.active;
    end

    assign readClear = regRdEn && (regAddr == ted_pkg::ADDR_TRANS_SRC);

    always_comb
    begin
        d = q;
        d.step = 1'b0;

        // Time step divider: base units of 1.25 ms, then units per step
        if (q.preCnt >= PRE_LAST)
        begin
            d.preCnt = '0;
            if (q.unitCnt >= stepUnits - 1'b1)
            begin
                d.unitCnt = '0;
                d.step = 1'b1;
            end
            else
            begin
                d.unitCnt = q.unitCnt + 1'b1;
            end
        end
        else
        begin
            d.preCnt = q.preCnt + 1'b1;
        end

        // Register writes; the source register is read only
        if (regWrEn)
        begin
            unique case (regAddr)
                ted_pkg::ADDR_MOTION_COUNT: d.motionCount = regWrData;
                ted_pkg::ADDR_TRANS_CFG: d.cfg = regWrData & ted_pkg::CFG_WRITE_MASK;
                ted_pkg::ADDR_TRANS_THS: d.ths = regWrData;
                ted_pkg::ADDR_TRANS_COUNT: d.transCount = regWrData;
                default: d.cfg = q.cfg;
            endcase
        end

        // Read data is registered; unmapped offsets read zero
        if (regRdEn)
        begin
            unique case (regAddr)
                ted_pkg::ADDR_MOTION_COUNT: d.rdData = q.motionCount;
                ted_pkg::ADDR_TRANS_CFG: d.rdData = q.cfg;
                ted_pkg::ADDR_TRANS_SRC: d.rdData = srcView;
                ted_pkg::ADDR_TRANS_THS: d.rdData = q.ths;
                ted_pkg::ADDR_TRANS_COUNT: d.rdData = q.transCount;
                default: d.rdData = ted_pkg::READ_ZERO;
            endcase
        end

        // Read side effect first, so an event in the same cycle survives
        if (readClear)
        begin
            d.evt = '0;
            d.pol = '0;
            d.active = 1'b0;
        end

        if (q.step)
        begin
            if (!q.cfg[ted_pkg::CFG_LATCH_BIT])
            begin
                // Live status: rewritten on every step
                d.evt = liveEvt;
                d.pol = livePol;
            end
            else if (!d.active)
            begin
                d.evt = liveEvt;
                d.pol = livePol;
            end
            else
            begin
                // Latched and active: add new axes, refresh their polarity only
                // An axis already flagged keeps its polarity frozen until the read
                d.pol = (d.pol & d.evt) | (livePol & ~d.evt);
                d.evt = d.evt | liveEvt;
            end
            d.active = |d.evt;
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            q.motionCount <= ted_pkg::RST_MOTION_COUNT;
            q.cfg <= ted_pkg::RST_TRANS_CFG;
            q.ths <= ted_pkg::RST_TRANS_THS;
            q.transCount <= ted_pkg::RST_TRANS_COUNT;
            q.evt <= '0;
            q.pol <= '0;
            q.active <= 1'b0;
            q.rdData <= ted_pkg::READ_ZERO;
            q.preCnt <= '0;
            q.unitCnt <= '0;
            q.step <= 1'b0;
        end
        else
        begin
            q <= d;
        end
    end

    // Transient channel debounce on any enabled axis over threshold
    assign transDbc.step = q.step;
    assign transDbc.cond = |axisOver;
    assign transDbc.clearMode = q.ths[ted_pkg::THS_MODE_BIT];
    assign transDbc.limit = q.transCount;

    ted_debounce u_trans_dbc (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .dbc(transDbc)
    );

    // Motion channel debounce; its condition and mode bit come from neighbour logic
    assign motionDbc.step = q.step;
    assign motionDbc.cond = motionCondition;
    assign motionDbc.clearMode = motionDebounceMode;
    assign motionDbc.limit = q.motionCount;

    ted_debounce u_motion_dbc (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .dbc(motionDbc)
    );

    assign regRdData = q.rdData;
    assign transientEventActive = q.active;
    assign transientIrq = q.active && transientIntEnable;
    assign motionEventFlag = motionDbc.match;
    assign debounceStep = q.step;
endmodule // transient_event_detector
